// ---- rtl/aofc_top.v ----
// Purpose: output stage configuration: clock phase, pair polarity, offset
// Assumes: axi4-lite slave, byte registers in the low data bits
// Notes: all outputs are registered; datapath has one cycle latency
`timescale 1ns/1ps
`default_nettype none
`include "aofc_consts.vh"

module aofc_top (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // axi4-lite write address
    input wire i_awvalid,
    input wire [9:0] i_awaddr,
    output reg o_awready,
    // axi4-lite write data
    input wire i_wvalid,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    output reg o_wready,
    // axi4-lite write response
    output reg o_bvalid,
    output reg [1:0] o_bresp,
    input wire i_bready,
    // axi4-lite read address
    input wire i_arvalid,
    input wire [9:0] i_araddr,
    output reg o_arready,
    // axi4-lite read data
    output reg o_rvalid,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    input wire i_rready,
    // converter samples in
    input wire i_sample_valid,
    input wire [`AOFC_SMP_W-1:0] i_sample,
    // formatted samples out
    output reg o_sample_valid,
    output reg [`AOFC_SMP_W-1:0] o_pair_data,
    // output clock control
    output reg o_phase_delay_enable,
    output reg [2:0] o_outclk_phase_select,
    // driver settings passed to the pad ring
    output reg [2:0] o_driver_current_select,
    output reg o_driver_load_enable
);

    ////////////////////////////////////////////////////////////////////
    // register storage

    reg [7:0] drv_load_reg;
    reg [7:0] phase_reg;
    reg [7:0] polarity_reg;
    reg [7:0] ofs_lo_reg;
    reg [7:0] ofs_hi_reg;
    reg [7:0] filter_reg;
    reg clip_seen_reg;
    reg phase_refused_reg;

    ////////////////////////////////////////////////////////////////////
    // axi write channel

    reg aw_held_reg;
    reg [7:0] aw_idx_reg;
    reg w_held_reg;
    reg [7:0] w_data_reg;
    reg w_lane_reg;
    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire [7:0] wr_idx;
    wire [7:0] wr_data;
    wire wr_lane;
    reg wr_hit;

    assign aw_take = i_awvalid && o_awready;
    assign w_take = i_wvalid && o_wready;
    assign wr_idx = aw_held_reg ? aw_idx_reg : i_awaddr[9:2];
    assign wr_data = w_held_reg ? w_data_reg : i_wdata[7:0];
    assign wr_lane = w_held_reg ? w_lane_reg : i_wstrb[0];
    // address and data may come in either order; fire once both are in
    assign wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take)
                     && !o_bvalid;

    always @* begin
        case (wr_idx)
            `AOFC_IDX_DRV_LOAD: wr_hit = 1'b1;
            `AOFC_IDX_PHASE: wr_hit = 1'b1;
            `AOFC_IDX_POLARITY: wr_hit = 1'b1;
            `AOFC_IDX_OFS_LO: wr_hit = 1'b1;
            `AOFC_IDX_OFS_HI: wr_hit = 1'b1;
            `AOFC_IDX_FILTER: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= `AOFC_RESP_OKAY;
            aw_held_reg <= 1'b0;
            aw_idx_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_hit ? `AOFC_RESP_OKAY : `AOFC_RESP_SLVERR;
                o_awready <= 1'b0;
                o_wready <= 1'b0;
            end else begin
                if (aw_take) begin
                    aw_held_reg <= 1'b1;
                    aw_idx_reg <= i_awaddr[9:2];
                end
                if (w_take) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= i_wdata[7:0];
                    w_lane_reg <= i_wstrb[0];
                end
                if (o_bvalid && i_bready) begin
                    o_bvalid <= 1'b0;
                end
                // ready only while idle for that channel
                o_awready <= !aw_held_reg && !aw_take && !o_bvalid;
                o_wready <= !w_held_reg && !w_take && !o_bvalid;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes (byte lane 0 only; other lanes have no storage)

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            drv_load_reg <= `AOFC_RST_DRV_LOAD;
            phase_reg <= `AOFC_RST_PHASE;
            polarity_reg <= `AOFC_RST_POLARITY;
            ofs_lo_reg <= `AOFC_RST_OFS;
            ofs_hi_reg <= `AOFC_RST_OFS;
            filter_reg <= `AOFC_RST_FILTER;
        end else if (wr_fire && wr_lane) begin
            case (wr_idx)
                `AOFC_IDX_DRV_LOAD: drv_load_reg <= wr_data;
                // factory bits are stored as written; software keeps them
                `AOFC_IDX_PHASE: phase_reg <= wr_data;
                `AOFC_IDX_POLARITY: polarity_reg <= wr_data;
                `AOFC_IDX_OFS_LO: ofs_lo_reg <= wr_data;
                `AOFC_IDX_OFS_HI: ofs_hi_reg <= wr_data;
                `AOFC_IDX_FILTER: filter_reg <= wr_data;
                default: drv_load_reg <= drv_load_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi read channel

    reg [7:0] rd_byte;
    reg rd_hit;
    wire [7:0] rd_idx;
    wire [7:0] status_byte;

    assign rd_idx = i_araddr[9:2];
    assign status_byte = {5'h00, phase_refused_reg, clip_seen_reg,
                          o_phase_delay_enable};

    always @* begin
        rd_hit = 1'b1;
        case (rd_idx)
            `AOFC_IDX_DRV_LOAD: rd_byte = drv_load_reg;
            `AOFC_IDX_PHASE: rd_byte = phase_reg;
            `AOFC_IDX_POLARITY: rd_byte = polarity_reg;
            `AOFC_IDX_OFS_LO: rd_byte = ofs_lo_reg;
            `AOFC_IDX_OFS_HI: rd_byte = ofs_hi_reg;
            `AOFC_IDX_FILTER: rd_byte = filter_reg;
            `AOFC_IDX_STATUS: rd_byte = status_byte;
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `AOFC_RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= {24'h00_0000, rd_byte};
                o_rresp <= rd_hit ? `AOFC_RESP_OKAY : `AOFC_RESP_SLVERR;
            end else if (o_rvalid) begin
                if (i_rready) begin
                    o_rvalid <= 1'b0;
                end
            end else begin
                o_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output clock phase decode

    wire ph_en;
    wire [2:0] ph_code;
    wire ph_odd;
    wire dec_above_two;
    wire fir_default;
    reg ph_allowed;

    assign ph_en = phase_reg[`AOFC_PH_EN_BIT];
    assign ph_code = phase_reg[`AOFC_PH_SEL_HI:`AOFC_PH_SEL_LO];
    assign ph_odd = ph_code[0];
    assign dec_above_two =
        filter_reg[`AOFC_DEC_HI:`AOFC_DEC_LO] > `AOFC_DEC_MIN_ODD;
    assign fir_default = !filter_reg[`AOFC_FIR_NDEF_BIT];

    // a code the current filter setup cannot make falls back to the
    // default phase rather than producing an undefined clock
    always @* begin
        if (ph_code == `AOFC_PH_ZERO) begin
            ph_allowed = 1'b1;
        end else if (ph_odd) begin
            ph_allowed = dec_above_two;
        end else begin
            ph_allowed = !fir_default;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_phase_delay_enable <= 1'b0;
            o_outclk_phase_select <= `AOFC_PH_ZERO;
            phase_refused_reg <= 1'b0;
        end else begin
            o_phase_delay_enable <= ph_en && ph_allowed;
            // shift is code * 45 degrees from the code-000 phase
            if (ph_en && ph_allowed) begin
                o_outclk_phase_select <= ph_code;
            end else begin
                o_outclk_phase_select <= `AOFC_PH_ZERO;
            end
            phase_refused_reg <= ph_en && !ph_allowed;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sample datapath: offset, saturation, pair polarity

    wire [`AOFC_SMP_W-1:0] adj_sample;
    wire adj_clip;
    wire [`AOFC_PAIRS-1:0] inv_mask;
    wire [`AOFC_SMP_W-1:0] inv_bits;

    aofc_offset_sat u_ofs (
        .i_sample(i_sample),
        .i_offset({ofs_hi_reg, ofs_lo_reg}),
        .o_result(adj_sample),
        .o_clipped(adj_clip)
    );

    // low two polarity bits are never looked at
    assign inv_mask = polarity_reg[`AOFC_POL_HI:`AOFC_POL_LO];

    // each ddr pair carries two sample bits; pair k holds bits 2k+1:2k
    genvar gp;
    generate
        for (gp = 0; gp < `AOFC_PAIRS; gp = gp + 1) begin : g_pair
            assign inv_bits[2*gp] = inv_mask[gp];
            assign inv_bits[2*gp+1] = inv_mask[gp];
        end
    endgenerate

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_sample_valid <= 1'b0;
            o_pair_data <= 12'h000;
            clip_seen_reg <= 1'b0;
        end else begin
            o_sample_valid <= i_sample_valid;
            if (i_sample_valid) begin
                o_pair_data <= adj_sample ^ inv_bits;
            end
            // clip flag is sticky, cleared by writing the offset low byte
            if (i_sample_valid && adj_clip) begin
                clip_seen_reg <= 1'b1;
            end else if (wr_fire && wr_lane &&
                         wr_idx == `AOFC_IDX_OFS_LO) begin
                clip_seen_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // driver settings are only carried out to the pads

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_driver_current_select <= `AOFC_RST_ISEL;
            o_driver_load_enable <= 1'b0;
        end else begin
            o_driver_current_select <= drv_load_reg[`AOFC_ISEL_HI:0];
            o_driver_load_enable <= drv_load_reg[`AOFC_LOAD_BIT];
        end
    end

endmodule
`default_nettype wire

// ---- rtl/aofc_consts.vh ----
// Purpose: constants for the output-format control block
// Assumes: byte registers, each in one aligned axi4-lite word
// Notes: byte address of a register is four times its index
// Function
// - phase code n shifts output clock by n times 45 degrees.
// - phase field ignored whenever phase_delay_enable is 0.
// - odd phase codes offered only when decimation setting exceeds 2.
// - filter config at defaults allows only the four odd-multiple shifts.
// - every non-zero phase is relative to the code 000 phase.
// - set polarity bit inverts its pair; msb maps to highest pair.
// - polarity field 000000 at reset leaves all six pairs uninverted.
// - two low polarity bits are stored but have no effect.
// - programmed offset is added to every converted sample.
// - offset is 16-bit two's complement from low and high bytes.
// - offset scaled 0.25 LSb per count; zero adds nothing.
// - upper offset byte sits in its own register, resets to zero.
`ifndef AOFC_CONSTS_VH
`define AOFC_CONSTS_VH

// register indices (byte address = index * 4)
`define AOFC_IDX_DRV_LOAD 8'h63
`define AOFC_IDX_PHASE 8'h64
`define AOFC_IDX_POLARITY 8'h65
`define AOFC_IDX_OFS_LO 8'h66
`define AOFC_IDX_OFS_HI 8'h67
`define AOFC_IDX_FILTER 8'h7A
`define AOFC_IDX_STATUS 8'h7F

// reset values
`define AOFC_RST_DRV_LOAD 8'h01
`define AOFC_RST_PHASE 8'h03
`define AOFC_RST_POLARITY 8'h00
`define AOFC_RST_OFS 8'h00
`define AOFC_RST_FILTER 8'h00

// phase register fields
`define AOFC_PH_EN_BIT 7
`define AOFC_PH_SEL_HI 6
`define AOFC_PH_SEL_LO 4
`define AOFC_PH_ZERO 3'h0

// polarity register fields
`define AOFC_POL_HI 7
`define AOFC_POL_LO 2

// filter register fields (decimation setting, config-a nondefault)
`define AOFC_DEC_HI 3
`define AOFC_DEC_LO 0
`define AOFC_FIR_NDEF_BIT 4
`define AOFC_DEC_MIN_ODD 4'h2

// widths
`define AOFC_SMP_W 12
`define AOFC_PAIRS 6
`define AOFC_FRAC_BITS 2

// driver register fields passed to the pads
`define AOFC_ISEL_HI 2
`define AOFC_LOAD_BIT 3
`define AOFC_RST_ISEL 3'h1

// axi responses
`define AOFC_RESP_OKAY 2'b00
`define AOFC_RESP_SLVERR 2'b10

`endif

// ---- rtl/aofc_offset_sat.v ----
// Purpose: add quarter-lsb offset to a sample and saturate
// Assumes: sample and offset are two's complement
// Notes: result truncates the two fraction bits toward minus infinity
`timescale 1ns/1ps
`default_nettype none
`include "aofc_consts.vh"

module aofc_offset_sat (
    // data in
    input wire [`AOFC_SMP_W-1:0] i_sample,
    input wire [15:0] i_offset,
    // data out
    output wire [`AOFC_SMP_W-1:0] o_result,
    output wire o_clipped
);
    localparam SW = `AOFC_SMP_W;
    localparam FW = `AOFC_FRAC_BITS;
    localparam AW = 18;

    wire signed [AW-1:0] smp_q;
    wire signed [AW-1:0] ofs_q;
    wire signed [AW-1:0] sum;
    wire signed [AW-FW-1:0] whole;
    wire [SW-1:0] max_v;
    wire [SW-1:0] min_v;
    wire over;
    wire under;

    // sample in quarter lsb units, offset sign-extended
    assign smp_q = {{(AW-SW-FW){i_sample[SW-1]}}, i_sample, {FW{1'b0}}};
    assign ofs_q = {{(AW-16){i_offset[15]}}, i_offset};
    assign sum = smp_q + ofs_q;
    assign whole = sum[AW-1:FW];
    assign max_v = {1'b0, {(SW-1){1'b1}}};
    assign min_v = {1'b1, {(SW-1){1'b0}}};
    assign over = !whole[AW-FW-1] && (|whole[AW-FW-2:SW-1]);
    assign under = whole[AW-FW-1] && !(&whole[AW-FW-2:SW-1]);
    // clip rather than wrap: a wrap flips full scale sign
    assign o_result = over ? max_v :
                      under ? min_v : whole[SW-1:0];
    assign o_clipped = over | under;
endmodule
`default_nettype wire

// ---- testbench/aofc_top_chk.sv ----
// Purpose: port-level checks on the output-format control top
// Assumes: one clock domain, synchronous active-low reset
// Notes: offset and filter state are internal, so arithmetic is benched
`timescale 1ns/1ps
`default_nettype none
module aofc_top_chk (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // register bus
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic i_rready,
    // sample path and pad controls
    input wire logic i_sample_valid,
    input wire logic o_sample_valid,
    input wire logic [11:0] o_pair_data,
    input wire logic o_phase_delay_enable,
    input wire logic [2:0] o_outclk_phase_select,
    input wire logic [2:0] o_driver_current_select,
    input wire logic o_driver_load_enable
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_WR_RESP: assert property (i_awvalid && o_awready && i_wvalid
        && o_wready |=> o_bvalid) else $error("no write response");
    AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid
        && $stable(o_bresp)) else $error("write response dropped");
    AST_B_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while response pending");
    AST_RD_RESP: assert property (i_arvalid && o_arready |=> o_rvalid
        && !o_arready) else $error("no read response");
    AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid
        && $stable(o_rdata) && $stable(o_rresp)) else $error("read moved");
    AST_R_BYTE: assert property (o_rvalid |-> o_rdata[31:8] == 24'h00_0000
        && (o_rresp != 2'b10 || o_rdata[7:0] == 8'h00))
        else $error("read data outside byte");
    AST_SMP_LAT: assert property (i_sample_valid |=> o_sample_valid)
        else $error("sample not passed in one cycle");
    AST_SMP_HOLD: assert property (!i_sample_valid |=> $stable(o_pair_data))
        else $error("pair data moved without a sample");
    AST_PH_OFF: assert property (!o_phase_delay_enable |->
        o_outclk_phase_select == 3'h0) else $error("phase set while off");
    AST_RST_VAL: assert property ($rose(i_rst_n) |->
        o_driver_current_select == 3'h1 && !o_driver_load_enable
        && !o_phase_delay_enable && o_pair_data == 12'h000)
        else $error("outputs not at reset values");
endmodule
bind aofc_top aofc_top_chk chk (.*);
`default_nettype wire

// ---- testbench/adc_output_format_ctrl_bench.sv ----
// Purpose: self-checking bench for the output-format control top
// Assumes: axi4-lite master below, byte address is four times the index
// Notes: expected samples come from a bench model of offset and inversion
`timescale 1ns/1ps
`default_nettype none
`include "aofc_consts.vh"
module adc_output_format_ctrl_bench;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_sample_valid = 1'b0;
    logic [9:0] i_awaddr = 10'h000, i_araddr = 10'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0] i_wstrb = 4'h0;
    logic [11:0] i_sample = 12'h000;
    wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire logic o_sample_valid, o_phase_delay_enable, o_driver_load_enable;
    wire logic [1:0] o_bresp, o_rresp;
    wire logic [31:0] o_rdata;
    wire logic [11:0] o_pair_data;
    wire logic [2:0] o_outclk_phase_select, o_driver_current_select;
    logic [33:0] exp_q[$];
    logic [11:0] smp_q[$];
    integer miscompares = 0, n_checks = 0, i;
    logic [31:0] seed = 32'hf8a92e94;
    logic [7:0] pol = 8'h00, f;
    logic [15:0] ofs = 16'h0000;
    logic [15:0] ofs_tab [6] = '{16'h0004, 16'hffff, 16'h7fff, 16'h8000,
        16'h0001, 16'hfffc};

    aofc_top uut (.*);

    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // floor of quarter-lsb sum, clamp, then invert the selected pairs
    function automatic logic [11:0] fmt(input logic [11:0] s);
        integer v, k;
        logic [11:0] m;
        begin
            v = ($signed(s) * 4 + $signed(ofs)) >>> 2;
            if (v > 2047) v = 2047;
            if (v < -2048) v = -2048;
            for (k = 0; k < 6; k = k + 1) m[2*k +: 2] = {2{pol[k+2]}};
            fmt = v[11:0] ^ m;
        end
    endfunction

    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        begin
            n_checks = n_checks + 1;
            if (seen !== want) begin
                miscompares = miscompares + 1;
                $display("unexpected at %0t: seen %h want %h", $time, seen,
                    want);
            end
        end
    endtask

    task automatic wrap_up;
        begin
            if (miscompares == 0 && n_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task automatic stall;
        begin
            miscompares = miscompares + 1;
            wrap_up;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] ix, input logic [7:0] d,
        input logic st, input logic [1:0] rs);
        integer n;
        begin
            exp_q.push_back({rs, 32'h0});
            i_awvalid <= 1'b1;
            i_awaddr <= {ix, 2'b00};
            i_wvalid <= 1'b1;
            i_wdata <= {24'h00_0000, d};
            i_wstrb <= {3'b000, st};
            i_bready <= 1'b1;
            for (n = 0; n < 40; n = n + 1) begin
                @(posedge i_ref_clk);
                if (i_awvalid && o_awready) i_awvalid <= 1'b0;
                if (i_wvalid && o_wready) i_wvalid <= 1'b0;
                if (o_bvalid) begin
                    i_bready <= 1'b0;
                    n = 99;
                end
            end
            if (n != 100) stall;
            @(posedge i_ref_clk);
        end
    endtask

    task automatic rd(input logic [7:0] ix, input logic [7:0] d,
        input logic [1:0] rs);
        integer n;
        begin
            exp_q.push_back({rs, 24'h00_0000, d});
            i_arvalid <= 1'b1;
            i_araddr <= {ix, 2'b00};
            i_rready <= 1'b1;
            for (n = 0; n < 40; n = n + 1) begin
                @(posedge i_ref_clk);
                if (i_arvalid && o_arready) i_arvalid <= 1'b0;
                if (o_rvalid) begin
                    i_rready <= 1'b0;
                    n = 99;
                end
            end
            if (n != 100) stall;
            @(posedge i_ref_clk);
        end
    endtask

    // results are judged in arrival order, one bus transfer at a time
    always @(posedge i_ref_clk) begin
        if (i_rst_n && o_bvalid && i_bready)
            chk({o_bresp, 32'h0}, exp_q.pop_front());
        if (i_rst_n && o_rvalid && i_rready)
            chk({o_rresp, o_rdata}, exp_q.pop_front());
        if (i_rst_n && o_sample_valid)
            chk({22'h0, o_pair_data}, {22'h0, smp_q.pop_front()});
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic smp(input logic [11:0] s);
        begin
            i_sample_valid <= 1'b1;
            i_sample <= s;
            smp_q.push_back(fmt(s));
            @(posedge i_ref_clk);
        end
    endtask

    // full-scale edges and zero first, then random samples back to back
    task automatic burst;
        integer j;
        begin
            smp(12'h7ff);
            smp(12'h800);
            smp(12'h000);
            for (j = 0; j < 5; j = j + 1) begin
                seed = lfsr(seed);
                smp(seed[11:0]);
            end
            i_sample_valid <= 1'b0;
            repeat (2) @(posedge i_ref_clk);
        end
    endtask

    task automatic do_reset;
        begin
            i_rst_n <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            i_rst_n <= 1'b1;
            repeat (2) @(posedge i_ref_clk);
            pol = 8'h00;
            ofs = 16'h0000;
        end
    endtask

    task automatic defaults;
        begin
            rd(`AOFC_IDX_DRV_LOAD, 8'h01, `AOFC_RESP_OKAY);
            rd(`AOFC_IDX_PHASE, 8'h03, `AOFC_RESP_OKAY);
            rd(`AOFC_IDX_POLARITY, 8'h00, `AOFC_RESP_OKAY);
            rd(`AOFC_IDX_OFS_LO, 8'h00, `AOFC_RESP_OKAY);
            rd(`AOFC_IDX_OFS_HI, 8'h00, `AOFC_RESP_OKAY);
            rd(`AOFC_IDX_STATUS, 8'h00, `AOFC_RESP_OKAY);
            chk({33'h0, o_phase_delay_enable}, 34'h0);
            chk({31'h0, o_driver_current_select}, 34'h1);
            burst;
        end
    endtask

    task automatic phase(input logic [7:0] fl, input logic en,
        input logic [2:0] c, input logic ok);
        begin
            wr(`AOFC_IDX_FILTER, fl, 1'b1, `AOFC_RESP_OKAY);
            wr(`AOFC_IDX_PHASE, {en, c, 4'h3}, 1'b1,
                `AOFC_RESP_OKAY);
            chk({33'h0, o_phase_delay_enable}, {33'h0, ok});
            chk({31'h0, o_outclk_phase_select},
                {31'h0, ok ? c : 3'h0});
            // clip flag is still set from the last offset burst
            rd(`AOFC_IDX_STATUS, {5'h00, en && !ok, 1'b1, ok},
                `AOFC_RESP_OKAY);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset;
        defaults;
        rd(8'h10, 8'h00, `AOFC_RESP_SLVERR);
        wr(8'h10, 8'h55, 1'b1, `AOFC_RESP_SLVERR);
        wr(`AOFC_IDX_STATUS, 8'h01, 1'b1, `AOFC_RESP_SLVERR);
        wr(`AOFC_IDX_DRV_LOAD, 8'h0a, 1'b1, `AOFC_RESP_OKAY);
        wr(`AOFC_IDX_DRV_LOAD, 8'h55, 1'b0, `AOFC_RESP_OKAY);
        rd(`AOFC_IDX_DRV_LOAD, 8'h0a, `AOFC_RESP_OKAY);
        chk({31'h0, o_driver_current_select}, 34'h2);
        chk({33'h0, o_driver_load_enable}, 34'h1);
        seed = lfsr(seed);
        for (i = 0; i < 5; i = i + 1) begin
            pol = (i == 0) ? 8'h04 : (i == 1) ? 8'h80 : (i == 2) ? 8'h03 :
                (i == 3) ? 8'hfc : seed[7:0];
            wr(`AOFC_IDX_POLARITY, pol, 1'b1, `AOFC_RESP_OKAY);
            rd(`AOFC_IDX_POLARITY, pol, `AOFC_RESP_OKAY);
            burst;
        end
        for (i = 0; i < 6; i = i + 1) begin
            ofs = ofs_tab[i];
            wr(`AOFC_IDX_OFS_LO, ofs[7:0], 1'b1, `AOFC_RESP_OKAY);
            wr(`AOFC_IDX_OFS_HI, ofs[15:8], 1'b1, `AOFC_RESP_OKAY);
            rd(`AOFC_IDX_OFS_HI, ofs[15:8], `AOFC_RESP_OKAY);
            burst;
            // only the +1/4 offset keeps every sample inside full scale
            rd(`AOFC_IDX_STATUS, {6'h00, i != 4, 1'b0},
                `AOFC_RESP_OKAY);
        end
        for (i = 0; i < 24; i = i + 1) begin
            f = (i < 8) ? 8'h03 : (i < 16) ? 8'h02 : 8'h13;
            phase(f, 1'b1, i[2:0], i[2:0] == 3'h0 ||
                (i[0] ? f[3:0] > 4'h2 : f[4]));
        end
        phase(8'h13, 1'b0, 3'h5, 1'b0);
        do_reset;
        defaults;
        wrap_up;
    end
endmodule
`default_nettype wire
